//--- design/eqs_pkg.sv
/*
 * Shared constants for the equalizer gain search controller: register
 * offsets, field positions, reset values, timing counts and states.
 * Assumes a single reference clock domain at the rate given below.
 */
package eqs_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_ERR_SRC = 8'h42;
    localparam logic [7:0] ADDR_SEARCH_CTL = 8'hD2;
    localparam logic [7:0] ADDR_READBACK = 8'hD3;
    localparam logic [7:0] ADDR_LIMITS = 8'hD5;

    // ************************************************************
    // Field layouts
    // ************************************************************
    localparam int GAIN_W = 4;
    localparam int CTL_RESTART_BIT = 0;
    localparam int CTL_AUTO_BIT = 1;
    localparam int CTL_FLOOR_EN_BIT = 2;
    localparam int CTL_DWELL_LSB = 3;
    localparam int DWELL_SEL_W = 3;
    localparam int SRC_CDR_BIT = 0;
    localparam int SRC_ENC_BIT = 1;
    localparam int SRC_PAR_BIT = 2;
    localparam int THOLD_LSB = 4;
    localparam int THOLD_W = 4;
    localparam int LIM_FLOOR_LSB = 0;
    localparam int LIM_CEIL_LSB = 4;
    localparam int RB_LOCKED_BIT = 4;
    localparam int ERR_CNT_W = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] ERR_SRC_RST = 8'h17;
    localparam logic [7:0] SEARCH_CTL_RST = 8'h1A;
    localparam logic [7:0] LIMITS_RST = 8'hF0;
    localparam logic [GAIN_W-1:0] MIN_GAIN_CODE = 4'h0;
    localparam logic [DWELL_SEL_W-1:0] DWELL_SEL_DEFAULT = 3'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int REF_CLK_MHZ = 250;
    localparam int DWELL_DEFAULT_NS = 2620000;
    localparam int DWELL_DEFAULT_CYCLES = DWELL_DEFAULT_NS / 1000 * REF_CLK_MHZ;
    localparam int TIMER_W = 24;

    // ************************************************************
    // Synchronised inputs
    // ************************************************************
    localparam int SYNC_CH = 6;
    localparam int SY_LOCK = 0;
    localparam int SY_LCLK = 1;
    localparam int SY_CDR = 2;
    localparam int SY_ENC = 3;
    localparam int SY_PAR = 4;
    localparam int SY_COMPAT = 5;

    // Search states, Gray along init -> dwell -> locked
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_DWELL = 2'b01,
        ST_LOCKED = 2'b11
    } eqs_state_type;

endpackage

//--- design/eqs_sync.sv
/*
 * Three-stage synchroniser bank for inputs from outside the reference
 * clock domain. A change is accepted once stages two and three agree.
 * Assumes inputs are slow relative to the reference clock.
 */
`timescale 1ns/10ps
module eqs_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [eqs_pkg::SYNC_CH-1:0] async_in,
    output logic [eqs_pkg::SYNC_CH-1:0] sync_out
);
    import eqs_pkg::*;

    genvar g;
    generate
        for (g = 0; g < SYNC_CH; g++) begin : g_ch
            logic s1_q, s2_q, s3_q, out_q;
            logic s1_d, s2_d, s3_d, out_d;
            // Next values; first stage only feeds the second
            always_comb begin
                s1_d = async_in[g];
                s2_d = s1_q;
                s3_d = s2_q;
                out_d = (s2_q == s3_q) ? s3_q : out_q;
            end
            // Register stage, frozen while ce is low
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    out_q <= 1'b0;
                end else if (ce) begin
                    s1_q <= s1_d;
                    s2_q <= s2_d;
                    s3_q <= s3_d;
                    out_q <= out_d;
                end
            end
            assign sync_out[g] = out_q;
        end
    endgenerate
endmodule // eqs_sync

//--- design/eqs_dwell_timer.sv
/*
 * Free-running dwell timer: restarts on start, pulses done on the last
 * cycle of each period, flags the first half of the period.
 * Assumes period is at least two cycles.
 */
`timescale 1ns/10ps
module eqs_dwell_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic [eqs_pkg::TIMER_W-1:0] period,
    output logic done,
    output logic first_half
);
    import eqs_pkg::*;

    logic [TIMER_W-1:0] cnt_q, cnt_d;

    // Decode of the running count; not gated by start, which keeps the
    // done-judge-start path free of a combinational loop. At-or-above also
    // ends a period that a shorter dwell select cut short.
    assign done = (cnt_q >= period - 1'b1);
    assign first_half = cnt_q < (period >> 1);

    // Count, wrap at end of period or on start
    always_comb begin
        if (start || done) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // Register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end
endmodule // eqs_dwell_timer

//--- design/eqs_search_ctrl.sv
/*
 * Equalizer gain search controller for one receive port: register file,
 * lock and error sampling, dwell timing and the gain stepping machine.
 * Assumes lock, link clock, error levels and the serializer-compatible
 * flag arrive asynchronously; register port and soft reset are on ref_clk.
 */
`timescale 1ns/10ps

// Contract
// - Step through permitted gain codes seeking one where recovery holds lock.
// - Wait the programmed dwell at each code before judging lock.
// - On valid lock freeze the gain code while lock stays asserted.
// - On lock loss advance to the next permitted code and search again.
// - Writing the restart bit in search control restarts the search anytime.
// - From power-on keep cycling codes, even with no incoming signal.
// - With compatible serializer, restart once after first lock unless disabled.
// - Any restart, bit or soft reset, begins again from minimum permitted code.
// - Never advance the gain code beyond the programmed ceiling.
// - Floor sets the starting code only while floor enable is set.
// - Reached gain code is readable from the readback register.
// - Dwell is programmable; default 2.62 ms.
// - At ceiling without lock, wrap to minimum code or enabled floor.
// - Each counted error source is individually selectable.
// - Errors accumulate over the first half of the dwell period.
// - Error count above the limit makes the search raise the gain code.
module eqs_search_ctrl #(
    parameter int DWELL_CYCLES = eqs_pkg::DWELL_DEFAULT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic core_soft_reset,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic cdr_lock,
    input wire logic link_clk,
    input wire logic cdr_error,
    input wire logic enc_error,
    input wire logic parity_error,
    input wire logic serializer_compatible,
    output logic [eqs_pkg::GAIN_W-1:0] eq_gain_code,
    output logic search_locked
);
    import eqs_pkg::*;

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    logic [SYNC_CH-1:0] async_in, sync_s;
    logic lock_s, compat_s, lclk_s;
    logic [2:0] err_s;

    assign async_in = {serializer_compatible, parity_error, enc_error, cdr_error,
                       link_clk, cdr_lock};

    eqs_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .async_in(async_in),
        .sync_out(sync_s)
    );

    assign lock_s = sync_s[SY_LOCK];
    assign lclk_s = sync_s[SY_LCLK];
    assign compat_s = sync_s[SY_COMPAT];
    assign err_s = {sync_s[SY_PAR], sync_s[SY_ENC], sync_s[SY_CDR]};

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0] err_src_q, err_src_d, ctl_q, ctl_d, lim_q, lim_d;
    logic restart_wr;

    // Restart bit is a write strobe, never stored, so it reads back as zero
    assign restart_wr = reg_wr_en && (reg_addr == ADDR_SEARCH_CTL)
                        && reg_wr_data[CTL_RESTART_BIT];

    // Writable registers; readback is read-only and ignores writes
    always_comb begin
        err_src_d = err_src_q;
        ctl_d = ctl_q;
        lim_d = lim_q;
        if (reg_wr_en) begin
            case (reg_addr)
                ADDR_ERR_SRC: begin
                    err_src_d = reg_wr_data;
                end
                ADDR_SEARCH_CTL: begin
                    ctl_d = reg_wr_data;
                    ctl_d[CTL_RESTART_BIT] = 1'b0;
                end
                ADDR_LIMITS: begin
                    lim_d = reg_wr_data;
                end
                default: begin
                    err_src_d = err_src_q;
                end
            endcase
        end
    end

    // Register the configuration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            err_src_q <= ERR_SRC_RST;
            ctl_q <= SEARCH_CTL_RST;
            lim_q <= LIMITS_RST;
        end else if (ce) begin
            err_src_q <= err_src_d;
            ctl_q <= ctl_d;
            lim_q <= lim_d;
        end
    end

    // ************************************************************
    // Configuration decode
    // ************************************************************
    logic [GAIN_W-1:0] floor_c, ceil_c, start_code, next_code;
    logic [THOLD_W-1:0] thold_c;
    logic [DWELL_SEL_W-1:0] dwell_sel;
    logic [2:0] src_en;
    logic floor_en, auto_en;
    logic [TIMER_W-1:0] dwell_base, dwell_period;

    assign floor_c = lim_q[LIM_FLOOR_LSB +: GAIN_W];
    assign ceil_c = lim_q[LIM_CEIL_LSB +: GAIN_W];
    assign thold_c = err_src_q[THOLD_LSB +: THOLD_W];
    assign src_en = {err_src_q[SRC_PAR_BIT], err_src_q[SRC_ENC_BIT],
                     err_src_q[SRC_CDR_BIT]};
    assign floor_en = ctl_d[CTL_FLOOR_EN_BIT]; // Restart written with it uses new floor
    assign auto_en = ctl_q[CTL_AUTO_BIT];
    assign dwell_sel = ctl_q[CTL_DWELL_LSB +: DWELL_SEL_W];

    // Dwell scales by powers of two around the default select
    assign dwell_base = TIMER_W'(DWELL_CYCLES >> DWELL_SEL_DEFAULT);
    assign dwell_period = dwell_base << dwell_sel;

    // Start at floor only when enabled; clamp so start never exceeds ceiling
    assign start_code = !floor_en ? MIN_GAIN_CODE
                      : (floor_c > ceil_c) ? ceil_c : floor_c;
    // Step up, wrapping to start once the ceiling is reached
    assign next_code = (eq_gain_code >= ceil_c) ? start_code
                     : GAIN_W'(eq_gain_code + 1'b1);

    // ************************************************************
    // Dwell timer and link clock edge
    // ************************************************************
    logic timer_start, timer_done, first_half;
    logic lclk_prev_q, lclk_prev_d, lclk_edge;

    eqs_dwell_timer u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .start(timer_start),
        .period(dwell_period),
        .done(timer_done),
        .first_half(first_half)
    );

    // Edge of the link clock as seen by ref_clk; stops harmlessly off-frame
    assign lclk_prev_d = lclk_s;
    assign lclk_edge = lclk_s && !lclk_prev_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lclk_prev_q <= 1'b0;
        end else if (ce) begin
            lclk_prev_q <= lclk_prev_d;
        end
    end

    // ************************************************************
    // Search state machine
    // ************************************************************
    eqs_state_type st_q, st_d;
    logic [GAIN_W-1:0] gain_d;
    logic [ERR_CNT_W-1:0] err_cnt_q, err_cnt_d;
    logic first_seen_q, first_seen_d, locked_d;
    logic restart_ev, judge, good, auto_fire, lock_lost;

    // Any of these begins a fresh search from the start code
    assign restart_ev = restart_wr || core_soft_reset;
    assign judge = (st_q == ST_DWELL) && timer_done;
    assign good = lock_s && (err_cnt_q <= ERR_CNT_W'(thold_c));
    assign auto_fire = judge && good && auto_en && compat_s && !first_seen_q;
    assign lock_lost = (st_q == ST_LOCKED) && !lock_s;
    assign timer_start = restart_ev || (st_q == ST_INIT) || lock_lost || auto_fire;

    // Next state, gain and error accumulator
    always_comb begin
        st_d = st_q;
        gain_d = eq_gain_code;
        err_cnt_d = err_cnt_q;
        first_seen_d = first_seen_q;
        if (restart_ev || (st_q == ST_INIT)) begin
            st_d = ST_DWELL;
            gain_d = start_code;
            err_cnt_d = '0;
            if (core_soft_reset) begin
                first_seen_d = 1'b0;
            end
        end else begin
            case (st_q)
                ST_DWELL: begin
                    // Count selected errors only in the first half of dwell
                    if (first_half && lclk_edge && |(err_s & src_en)
                        && (err_cnt_q != {ERR_CNT_W{1'b1}})) begin
                        err_cnt_d = err_cnt_q + 1'b1;
                    end
                    if (judge) begin
                        err_cnt_d = '0;
                        if (auto_fire) begin
                            first_seen_d = 1'b1;
                            gain_d = start_code;
                        end else if (good) begin
                            first_seen_d = 1'b1;
                            st_d = ST_LOCKED;
                        end else begin
                            // No lock anywhere keeps this loop running from power-on
                            gain_d = next_code;
                        end
                    end
                end
                ST_LOCKED: begin
                    if (!lock_s) begin
                        st_d = ST_DWELL;
                        gain_d = next_code;
                        err_cnt_d = '0;
                    end
                end
                default: begin
                    st_d = ST_INIT;
                end
            endcase
        end
    end
    assign locked_d = (st_d == ST_LOCKED);

    // Register the search state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= ST_INIT;
            eq_gain_code <= MIN_GAIN_CODE;
            err_cnt_q <= '0;
            first_seen_q <= 1'b0;
            search_locked <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            eq_gain_code <= gain_d;
            err_cnt_q <= err_cnt_d;
            first_seen_q <= first_seen_d;
            search_locked <= locked_d;
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    logic [7:0] rd_d;

    // One-cycle read latency; unmapped offsets read as zero
    always_comb begin
        rd_d = reg_rd_data;
        if (reg_rd_en) begin
            case (reg_addr)
                ADDR_ERR_SRC: rd_d = err_src_q;
                ADDR_SEARCH_CTL: rd_d = ctl_q;
                ADDR_READBACK: begin
                    rd_d = 8'h00;
                    rd_d[GAIN_W-1:0] = eq_gain_code;
                    rd_d[RB_LOCKED_BIT] = search_locked;
                end
                ADDR_LIMITS: rd_d = lim_q;
                default: rd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
        end else if (ce) begin
            reg_rd_data <= rd_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence seq_lock_lost;
        ce && lock_lost && !restart_ev;
    endsequence

    sequence seq_fail_at_ceiling;
        ce && judge && !good && !restart_ev && (eq_gain_code >= ceil_c);
    endsequence

    AST_HOLD_LOCKED: assert property (
        @(posedge ref_clk) disable iff (rst)
        (st_q == ST_LOCKED) && lock_s && !restart_ev |=> $stable(eq_gain_code))
        else $error("gain changed while locked");

    AST_ADVANCE_ON_LOSS: assert property (
        @(posedge ref_clk) disable iff (rst)
        seq_lock_lost |=> (st_q == ST_DWELL) && (eq_gain_code == $past(next_code))
        && !search_locked)
        else $error("lock loss did not advance gain");

    AST_RESTART_START: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && restart_ev |=> (eq_gain_code == $past(start_code)) && (err_cnt_q == 0))
        else $error("restart did not load start code");

    AST_WRAP_AT_CEIL: assert property (
        @(posedge ref_clk) disable iff (rst)
        seq_fail_at_ceiling |=> eq_gain_code == $past(start_code))
        else $error("no wrap at ceiling");

    AST_CEILING: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && judge && !restart_ev && !(ceil_c < floor_c) |=> eq_gain_code <= ceil_c)
        else $error("gain above ceiling");

    AST_ERR_RAISE: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && judge && !restart_ev && (err_cnt_q > ERR_CNT_W'(thold_c))
        && (eq_gain_code < ceil_c) |=> eq_gain_code == $past(eq_gain_code) + 1'b1)
        else $error("errors over limit did not raise gain");

    AST_COUNT_FIRST_HALF: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && !first_half && !timer_start && !judge |=> $stable(err_cnt_q))
        else $error("errors counted in second half");

    AST_ERR_CLEAR: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && (judge || timer_start) |=> err_cnt_q == 0)
        else $error("accumulator not cleared at dwell start");

    AST_READBACK: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && reg_rd_en && (reg_addr == ADDR_READBACK)
        |=> reg_rd_data[GAIN_W-1:0] == $past(eq_gain_code))
        else $error("readback mismatch");

    AST_AUTO_RESTART: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && auto_fire && !restart_ev |=> !search_locked && first_seen_q
        && (eq_gain_code == $past(start_code)))
        else $error("first lock did not restart search");

endmodule // eqs_search_ctrl

//--- dv/eqs_serializer_model.sv
/*
 * Behavioural remote serializer at the far end of the forward link.
 * Assumes the bench picks the gain code that locks and when errors occur.
 */
`timescale 1ns/10ps
module eqs_serializer_model (
    input wire logic sig_on,
    input wire logic [eqs_pkg::GAIN_W-1:0] lock_code,
    input wire logic err_on,
    input wire logic compat,
    input wire logic [eqs_pkg::GAIN_W-1:0] eq_gain_code,
    output logic link_clk,
    output logic cdr_lock,
    output logic cdr_error,
    output logic enc_error,
    output logic parity_error,
    output logic serializer_compatible
);
    import eqs_pkg::*;

    // ************************************************************
    // Link clock and line state
    // ************************************************************
    // Clock stands low with no signal; odd offset keeps it off ref_clk edges
    initial begin
        link_clk = 1'b0;
        #13;
        forever begin
            #40;
            link_clk = sig_on ? ~link_clk : 1'b0;
        end
    end

    // Lock only at the one gain that suits this channel
    assign cdr_lock = sig_on && (eq_gain_code == lock_code);
    assign cdr_error = sig_on && err_on;
    assign enc_error = sig_on && err_on;
    assign parity_error = sig_on && err_on;
    assign serializer_compatible = compat;
endmodule // eqs_serializer_model

//--- dv/tb_adaptive_eq_search_control.sv
/*
 * Self-checking bench for the gain search controller with a serializer model.
 * Assumes DWELL_CYCLES of 64, so select 3 gives 64 cycles, select 5 gives 256.
 */
`timescale 1ns/10ps
module tb_adaptive_eq_search_control;
    import eqs_pkg::*;

    logic ref_clk, rst, ce, core_soft_reset, reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rd_val;
    logic link_clk, cdr_lock, cdr_error, enc_error, parity_error, serializer_compatible;
    logic [GAIN_W-1:0] eq_gain_code, lock_code;
    logic search_locked, sig_on, err_on, compat;
    int err_count, checked;

    // ************************************************************
    // Design, partner and clock
    // ************************************************************
    eqs_search_ctrl #(.DWELL_CYCLES(64)) dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .core_soft_reset(core_soft_reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .cdr_lock(cdr_lock), .link_clk(link_clk), .cdr_error(cdr_error),
        .enc_error(enc_error), .parity_error(parity_error),
        .serializer_compatible(serializer_compatible), .eq_gain_code(eq_gain_code),
        .search_locked(search_locked));

    eqs_serializer_model ser_u (.sig_on(sig_on), .lock_code(lock_code), .err_on(err_on),
        .compat(compat), .eq_gain_code(eq_gain_code), .link_clk(link_clk),
        .cdr_lock(cdr_lock), .cdr_error(cdr_error), .enc_error(enc_error),
        .parity_error(parity_error), .serializer_compatible(serializer_compatible));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Access tasks and checks
    // ************************************************************
    task automatic summarize;
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Strobe stands one edge, then drops; next call waits for a fresh edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= addr;
        reg_wr_data <= data;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= addr;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1;
        rd_val = reg_rd_data;
    endtask

    // Bounded wait for the search to settle
    task automatic wait_lock(input int maxc);
        int i;
        for (i = 0; i < maxc && search_locked !== 1'b1; i++) cyc(1);
        if (search_locked !== 1'b1) begin
            err_count++;
            summarize();
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        int k, c, s;
        logic [7:0] ctl_tab[2];
        ctl_tab = '{8'h1D, 8'h19};
        err_count = 0;
        checked = 0;
        {rst, ce, core_soft_reset, reg_wr_en, reg_rd_en} = 5'b11000;
        {reg_addr, reg_wr_data} = 16'h0000;
        {sig_on, err_on, compat} = 3'b000;
        lock_code = 4'h0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values of the writable registers, unmapped read
        rd(ADDR_ERR_SRC); chk(rd_val, ERR_SRC_RST);
        rd(ADDR_SEARCH_CTL); chk(rd_val, SEARCH_CTL_RST);
        rd(ADDR_LIMITS); chk(rd_val, LIMITS_RST);
        rd(8'h00); chk(rd_val, 8'h00);
        // Stepping with no signal, ceiling 2, wrap to minimum
        wr(ADDR_LIMITS, 8'h20);
        wr(ADDR_SEARCH_CTL, 8'h19);
        cyc(30);
        wr(ADDR_READBACK, 8'hFF);
        rd(ADDR_READBACK); chk(rd_val, 8'h00);
        cyc(62);
        // Sample mid-dwell, well away from the edges where the gain steps
        for (k = 1; k < 5; k++) begin
            chk({4'h0, eq_gain_code}, 8'(k % 3));
            cyc(64);
        end
        // Floor used as start only while enabled; floor 1, ceiling 3
        wr(ADDR_LIMITS, 8'h31);
        for (c = 0; c < 2; c++) begin
            wr(ADDR_SEARCH_CTL, ctl_tab[c]);
            cyc(32);
            for (k = 0; k < 5; k++) begin
                chk({4'h0, eq_gain_code}, 8'((1 - c) + k % (3 + c)));
                cyc(64);
            end
        end
        // Lock, hold, loss and reacquire
        wr(ADDR_LIMITS, 8'hF0);
        lock_code = 4'h2;
        sig_on = 1'b1;
        wr(ADDR_SEARCH_CTL, 8'h19);
        wait_lock(400); chk({4'h0, eq_gain_code}, 8'h02);
        rd(ADDR_READBACK); chk(rd_val, 8'h12);
        cyc(300); chk({3'h0, search_locked, eq_gain_code}, 8'h12);
        // Clock enable low freezes the search even as lock goes away
        @(posedge ref_clk);
        ce <= 1'b0;
        lock_code = 4'h5;
        cyc(20); chk({3'h0, search_locked, eq_gain_code}, 8'h12);
        @(posedge ref_clk);
        ce <= 1'b1;
        cyc(10); chk({3'h0, search_locked, eq_gain_code}, 8'h03);
        wait_lock(400); chk({4'h0, eq_gain_code}, 8'h05);
        // Soft reset, then one automatic restart after first lock
        lock_code = 4'h1;
        compat = 1'b1;
        wr(ADDR_SEARCH_CTL, 8'h1A);
        @(posedge ref_clk);
        core_soft_reset <= 1'b1;
        @(posedge ref_clk);
        core_soft_reset <= 1'b0;
        cyc(32); chk({4'h0, eq_gain_code}, 8'h00);
        cyc(128); chk({3'h0, search_locked, eq_gain_code}, 8'h00);
        cyc(128); chk({3'h0, search_locked, eq_gain_code}, 8'h11);
        // Each error source alone forces a raise; none selected allows lock
        compat = 1'b0;
        lock_code = 4'h0;
        err_on = 1'b1;
        wr(ADDR_LIMITS, 8'h10);
        for (s = 0; s < 4; s++) begin
            wr(ADDR_ERR_SRC, 8'h10 | 8'((1 << s) & 7));
            wr(ADDR_SEARCH_CTL, 8'h29);
            cyc(384);
            chk({3'h0, search_locked, eq_gain_code}, (s < 3) ? 8'h01 : 8'h10);
        end
        summarize();
    end

    // Whole-run watchdog
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule // tb_adaptive_eq_search_control
